// ---- design/dhl_config_bank.sv ----
/*
  Holdover, pull-in limit, crystal calibration and interrupt mask register bank.
  Assumes a synchronous 8-bit register port and that the DPLL, the averagers and
  the event sources run on the same system clock.
*/
`timescale 1ns/1ps

// Function
// - With the limit bit set, hold the integral path at minimum or maximum frequency.
// - While the integral path is held, freeze the reported loop frequency.
// - The 16-bit calibration word is a ppm offset from 12.8 MHz nominal.
// - Frequency monitors keep the uncalibrated crystal value.
// - Manual holdover value is 19 bits signed from three register parts.
// - Except in frozen, fast or slow mini holdover, manual control uses manual value, otherwise auto-averaging uses averaged value, otherwise frozen value.
// - Read-average bit picks written value or averaged value on read.
// - Fourteen input mask bits gate interrupts; masks reset to zero.
// - Operating mode changes interrupt only when their mask bit is set.
// - Main reference failure interrupts only when its mask bit is set.
// - Secondary path state changes interrupt only when their mask bit is set.
module dhl_config_bank #(
  parameter int FREQ_W = dhl_pkg::DHL_FREQ_W,
  parameter int LIM_SCALE = dhl_pkg::DHL_LIM_SCALE
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire dhl_pkg::dhl_bus_type I_BUS,
  output logic [7:0] O_RD_DATA,
  input wire dhl_pkg::dhl_loop_mode_type I_MODE,
  input wire logic signed [FREQ_W-1:0] I_T0_FREQ,
  input wire logic signed [FREQ_W-1:0] I_T4_FREQ,
  input wire logic signed [FREQ_W-1:0] I_FAST_AVG_FREQ,
  input wire logic signed [FREQ_W-1:0] I_SLOW_AVG_FREQ,
  input wire dhl_pkg::dhl_event_type I_EVENTS,
  input wire dhl_pkg::dhl_event_type I_STATUS_CLR,
  output dhl_pkg::dhl_event_type O_STATUS,
  output logic O_IRQ,
  output logic O_T0_INT_HOLD,
  output logic O_T4_INT_HOLD,
  output logic signed [FREQ_W-1:0] O_REPORTED_FREQ,
  output logic signed [FREQ_W-1:0] O_HOLDOVER_FREQ,
  output logic [dhl_pkg::DHL_CAL_W-1:0] O_LOOP_XTAL_CAL,
  output logic [dhl_pkg::DHL_CAL_W-1:0] O_MON_XTAL_CAL,
  output logic [dhl_pkg::DHL_LIM_W-1:0] O_PULL_IN_BOUND,
  output logic O_AUTO_BW_SEL
);
  import dhl_pkg::*;

  logic [7:0] auto_bw_q;
  logic [7:0] cal_lo_q;
  logic [7:0] cal_hi_q;
  logic [7:0] hold_lo_q;
  logic [7:0] hold_mid_q;
  logic [7:0] hold_mode_q;
  logic [7:0] lim_lo_q;
  logic [DHL_LIM_TOP_W-1:0] lim_hi_q;
  logic [7:0] mask_lo_q;
  logic [7:0] mask_mid_q;
  logic mask_t4_q;
  logic signed [FREQ_W-1:0] frozen_q;
  logic signed [FREQ_W-1:0] reported_q;
  logic signed [FREQ_W-1:0] holdover_q;
  logic signed [FREQ_W-1:0] holdover_d;
  logic signed [FREQ_W-1:0] manual_freq;
  logic signed [FREQ_W-1:0] avg_freq;
  logic signed [FREQ_W-1:0] read_freq;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic in_hold_q;
  logic int_limit_en;
  logic t0_at_max;
  logic t0_at_min;
  logic t4_at_max;
  logic t4_at_min;
  logic [DHL_LIM_W-1:0] bound;
  dhl_event_type status_q;
  dhl_event_type mask_vec;
  dhl_mini_type mini_mode;

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      auto_bw_q <= DHL_RST_AUTO_BW;
      cal_lo_q <= DHL_RST_CAL_LO;
      cal_hi_q <= DHL_RST_CAL_HI;
      hold_lo_q <= DHL_RST_HOLD;
      hold_mid_q <= DHL_RST_HOLD;
      hold_mode_q <= DHL_RST_HOLD_MODE;
      lim_lo_q <= DHL_RST_LIM_LO;
      lim_hi_q <= DHL_RST_LIM_HI[DHL_LIM_TOP_W-1:0];
      mask_lo_q <= DHL_RST_MASK;
      mask_mid_q <= DHL_RST_MASK;
      mask_t4_q <= DHL_RST_MASK[DHL_BIT_MASK_T4];
    end else if (I_BUS.wr) begin
      unique case (I_BUS.addr)
        DHL_ADDR_AUTO_BW: begin
          auto_bw_q[DHL_BIT_AUTO_BW_SEL] <= I_BUS.wdata[DHL_BIT_AUTO_BW_SEL];
          auto_bw_q[DHL_BIT_INT_LIMIT] <= I_BUS.wdata[DHL_BIT_INT_LIMIT];
        end
        DHL_ADDR_CAL_LO: cal_lo_q <= I_BUS.wdata;
        DHL_ADDR_CAL_HI: cal_hi_q <= I_BUS.wdata;
        DHL_ADDR_HOLD_LO: hold_lo_q <= I_BUS.wdata;
        DHL_ADDR_HOLD_MID: hold_mid_q <= I_BUS.wdata;
        DHL_ADDR_HOLD_MODE: hold_mode_q <= I_BUS.wdata;
        DHL_ADDR_LIM_LO: lim_lo_q <= I_BUS.wdata;
        DHL_ADDR_LIM_HI: lim_hi_q <= I_BUS.wdata[DHL_LIM_TOP_W-1:0];
        DHL_ADDR_MASK_LO: mask_lo_q <= I_BUS.wdata;
        DHL_ADDR_MASK_MID: mask_mid_q <= I_BUS.wdata;
        DHL_ADDR_MASK_HI: mask_t4_q <= I_BUS.wdata[DHL_BIT_MASK_T4];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------------------
  assign int_limit_en = auto_bw_q[DHL_BIT_INT_LIMIT];
  assign O_AUTO_BW_SEL = auto_bw_q[DHL_BIT_AUTO_BW_SEL];
  // The loop sees the calibrated crystal; the monitors deliberately do not, so
  // their thresholds stay tied to the raw oscillator.
  assign O_LOOP_XTAL_CAL = {cal_hi_q, cal_lo_q};
  assign O_MON_XTAL_CAL = DHL_CAL_NOMINAL;
  assign manual_freq = {hold_mode_q[DHL_HOLD_TOP_W-1:0], hold_mid_q, hold_lo_q};
  assign avg_freq = hold_mode_q[DHL_BIT_FAST_AVG] ? I_FAST_AVG_FREQ
                                                  : I_SLOW_AVG_FREQ;
  assign mini_mode = dhl_mini_type'(hold_mode_q[DHL_MINI_HI:DHL_MINI_LO]);
  assign bound = {lim_hi_q, lim_lo_q};
  assign O_PULL_IN_BOUND = bound;

  // ----------------------------------------------------------------------------
  // Integral limiting for both loops
  // ----------------------------------------------------------------------------
  dhl_pull_in_limiter #(
    .FREQ_W(FREQ_W),
    .LIM_W(DHL_LIM_W),
    .LIM_SCALE(LIM_SCALE)
  ) u_t0_limit (
    .i_freq(I_T0_FREQ),
    .i_bound(bound),
    .i_enable(int_limit_en),
    .o_at_max(t0_at_max),
    .o_at_min(t0_at_min),
    .o_hold(O_T0_INT_HOLD)
  );

  dhl_pull_in_limiter #(
    .FREQ_W(FREQ_W),
    .LIM_W(DHL_LIM_W),
    .LIM_SCALE(LIM_SCALE)
  ) u_t4_limit (
    .i_freq(I_T4_FREQ),
    .i_bound(bound),
    .i_enable(int_limit_en),
    .o_at_max(t4_at_max),
    .o_at_min(t4_at_min),
    .o_hold(O_T4_INT_HOLD)
  );

  // Reported value tracks the loop except while its integral path is held.
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      reported_q <= '0;
    end else if (!O_T0_INT_HOLD) begin
      reported_q <= I_T0_FREQ;
    end
  end

  assign O_REPORTED_FREQ = reported_q;

  // ----------------------------------------------------------------------------
  // Holdover frequency selection
  // ----------------------------------------------------------------------------
  // The frozen value is caught on the cycle the loop enters either holdover
  // state, so it is the last locked frequency rather than a later drift.
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      in_hold_q <= 1'b0;
      frozen_q <= '0;
    end else begin
      in_hold_q <= I_MODE.in_holdover | I_MODE.in_mini_holdover;
      if (!in_hold_q && (I_MODE.in_holdover || I_MODE.in_mini_holdover)) begin
        frozen_q <= reported_q;
      end
    end
  end

  // Manual holdover control overrides auto-averaging, so software can pin the
  // holdover word even while the averager stays enabled.
  always_comb begin
    if (I_MODE.manual_holdover) begin
      holdover_d = manual_freq;
    end else if (hold_mode_q[DHL_BIT_AUTO_AVG]) begin
      holdover_d = avg_freq;
    end else begin
      holdover_d = frozen_q;
    end
    if (I_MODE.in_mini_holdover && !I_MODE.in_holdover) begin
      unique case (mini_mode)
        DHL_MINI_FULL: holdover_d = holdover_d;
        DHL_MINI_FROZEN: holdover_d = frozen_q;
        DHL_MINI_FAST: holdover_d = I_FAST_AVG_FREQ;
        DHL_MINI_SLOW: holdover_d = I_SLOW_AVG_FREQ;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      holdover_q <= '0;
    end else begin
      holdover_q <= holdover_d;
    end
  end

  assign O_HOLDOVER_FREQ = holdover_q;

  // ----------------------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------------------
  // Flags record every event whatever the mask; a set in the same cycle as a
  // clear wins so that no event is lost.
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~I_STATUS_CLR) | I_EVENTS;
    end
  end

  assign mask_vec.inputs = {mask_mid_q[DHL_N_INPUTS-9:0], mask_lo_q};
  assign mask_vec.op_mode = mask_mid_q[DHL_BIT_MASK_OPMODE];
  assign mask_vec.main_ref = mask_mid_q[DHL_BIT_MASK_MAINREF];
  assign mask_vec.t4_state = mask_t4_q;
  assign O_IRQ = |(status_q & mask_vec);
  assign O_STATUS = status_q;

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  assign read_freq = hold_mode_q[DHL_BIT_READ_AVG] ? avg_freq : manual_freq;

  always_comb begin
    rdata_d = DHL_RD_UNMAPPED;
    unique case (I_BUS.addr)
      DHL_ADDR_AUTO_BW: rdata_d = auto_bw_q;
      DHL_ADDR_CAL_LO: rdata_d = cal_lo_q;
      DHL_ADDR_CAL_HI: rdata_d = cal_hi_q;
      DHL_ADDR_HOLD_LO: rdata_d = read_freq[7:0];
      DHL_ADDR_HOLD_MID: rdata_d = read_freq[15:8];
      DHL_ADDR_HOLD_MODE: begin
        rdata_d = hold_mode_q;
        rdata_d[DHL_HOLD_TOP_W-1:0] = read_freq[FREQ_W-1:16];
      end
      DHL_ADDR_LIM_LO: rdata_d = lim_lo_q;
      DHL_ADDR_LIM_HI: rdata_d = {6'h00, lim_hi_q};
      DHL_ADDR_MASK_LO: rdata_d = mask_lo_q;
      DHL_ADDR_MASK_MID: rdata_d = mask_mid_q;
      DHL_ADDR_MASK_HI: rdata_d = {1'b0, mask_t4_q, 6'h00};
      default: rdata_d = DHL_RD_UNMAPPED;
    endcase
  end

  // Read data is registered, one cycle after the read strobe, and holds.
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      rdata_q <= DHL_RD_UNMAPPED;
    end else if (I_BUS.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign O_RD_DATA = rdata_q;

endmodule

// ---- design/dhl_pkg.sv ----
/*
  Shared constants and types for the holdover, pull-in limit and interrupt mask
  configuration bank.
  Assumes one system clock and an 8-bit microprocessor register port.
*/
package dhl_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] DHL_ADDR_AUTO_BW = 8'h3B;
  localparam logic [7:0] DHL_ADDR_CAL_LO = 8'h3C;
  localparam logic [7:0] DHL_ADDR_CAL_HI = 8'h3D;
  localparam logic [7:0] DHL_ADDR_HOLD_LO = 8'h3E;
  localparam logic [7:0] DHL_ADDR_HOLD_MID = 8'h3F;
  localparam logic [7:0] DHL_ADDR_HOLD_MODE = 8'h40;
  localparam logic [7:0] DHL_ADDR_LIM_LO = 8'h41;
  localparam logic [7:0] DHL_ADDR_LIM_HI = 8'h42;
  localparam logic [7:0] DHL_ADDR_MASK_LO = 8'h43;
  localparam logic [7:0] DHL_ADDR_MASK_MID = 8'h44;
  localparam logic [7:0] DHL_ADDR_MASK_HI = 8'h45;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] DHL_RST_AUTO_BW = 8'h88;
  localparam logic [7:0] DHL_RST_CAL_LO = 8'h99;
  localparam logic [7:0] DHL_RST_CAL_HI = 8'h99;
  localparam logic [7:0] DHL_RST_HOLD = 8'h00;
  localparam logic [7:0] DHL_RST_HOLD_MODE = 8'h88;
  localparam logic [7:0] DHL_RST_LIM_LO = 8'h76;
  localparam logic [7:0] DHL_RST_LIM_HI = 8'h00;
  localparam logic [7:0] DHL_RST_MASK = 8'h00;
  localparam logic [7:0] DHL_RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int DHL_BIT_AUTO_BW_SEL = 7;
  localparam int DHL_BIT_INT_LIMIT = 3;
  localparam int DHL_BIT_AUTO_AVG = 7;
  localparam int DHL_BIT_FAST_AVG = 6;
  localparam int DHL_BIT_READ_AVG = 5;
  localparam int DHL_MINI_HI = 4;
  localparam int DHL_MINI_LO = 3;
  localparam int DHL_HOLD_TOP_W = 3;
  localparam int DHL_LIM_TOP_W = 2;
  localparam int DHL_BIT_MASK_OPMODE = 7;
  localparam int DHL_BIT_MASK_MAINREF = 6;
  localparam int DHL_BIT_MASK_T4 = 6;

  // ----------------------------------------------------------------------------
  // Widths and derived values
  // ----------------------------------------------------------------------------
  localparam int DHL_FREQ_W = 19;
  localparam int DHL_LIM_W = 10;
  localparam int DHL_CAL_W = 16;
  localparam int DHL_N_INPUTS = 14;
  localparam int DHL_LIM_SCALE = 7136;
  // Calibration word that stands for the nominal 12.8 MHz crystal.
  localparam logic [15:0] DHL_CAL_NOMINAL = 16'h9999;

  typedef enum logic [1:0] {
    DHL_MINI_FULL = 2'h0,
    DHL_MINI_FROZEN = 2'h1,
    DHL_MINI_FAST = 2'h2,
    DHL_MINI_SLOW = 2'h3
  } dhl_mini_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dhl_bus_type;

  typedef struct packed {
    logic [DHL_N_INPUTS-1:0] inputs;
    logic op_mode;
    logic main_ref;
    logic t4_state;
  } dhl_event_type;

  typedef struct packed {
    logic in_holdover;
    logic in_mini_holdover;
    logic manual_holdover;
  } dhl_loop_mode_type;

endpackage

// ---- design/dhl_pull_in_limiter.sv ----
/*
  Pull-in bound check for one DPLL frequency word.
  Assumes the loop frequency is a signed word relative to the calibrated crystal.
*/
`timescale 1ns/1ps

module dhl_pull_in_limiter #(
  parameter int FREQ_W = 19,
  parameter int LIM_W = 10,
  parameter int LIM_SCALE = 7136
) (
  input wire logic signed [FREQ_W-1:0] i_freq,
  input wire logic [LIM_W-1:0] i_bound,
  input wire logic i_enable,
  output logic o_at_max,
  output logic o_at_min,
  output logic o_hold
);
  localparam int PW = LIM_W + 14;
  localparam int CW = (PW > FREQ_W ? PW : FREQ_W) + 1;

  logic [PW-1:0] product;
  logic signed [CW-1:0] upper;
  logic signed [CW-1:0] lower;
  logic signed [CW-1:0] freq_x;

  // ----------------------------------------------------------------------------
  // Symmetric bound
  // ----------------------------------------------------------------------------
  // The same bound serves the positive and negative side.
  assign product = PW'(i_bound) * PW'(LIM_SCALE);
  assign upper = $signed(CW'(product));
  assign lower = -upper;
  assign freq_x = CW'(i_freq);
  assign o_at_max = freq_x >= upper;
  assign o_at_min = freq_x <= lower;
  assign o_hold = i_enable & (o_at_max | o_at_min);

endmodule

// ---- dv/dhl_config_bank_monitor.sv ----
/*
  Port checker for the holdover and interrupt mask register bank.
  Assumes it is bound to dhl_config_bank and sees only its ports.
*/
`timescale 1ns/1ps

module dhl_monitor #(
  parameter int FREQ_W = 19,
  parameter int LIM_SCALE = 7136
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire dhl_pkg::dhl_bus_type I_BUS,
  input wire logic [7:0] O_RD_DATA,
  input wire logic signed [FREQ_W-1:0] I_T0_FREQ,
  input wire dhl_pkg::dhl_event_type I_EVENTS,
  input wire dhl_pkg::dhl_event_type O_STATUS,
  input wire logic O_IRQ,
  input wire logic O_T0_INT_HOLD,
  input wire logic signed [FREQ_W-1:0] O_REPORTED_FREQ,
  input wire logic [dhl_pkg::DHL_CAL_W-1:0] O_LOOP_XTAL_CAL,
  input wire logic [dhl_pkg::DHL_CAL_W-1:0] O_MON_XTAL_CAL,
  input wire logic [dhl_pkg::DHL_LIM_W-1:0] O_PULL_IN_BOUND
);
  import dhl_pkg::*;
  // ---------------------------------------------------------------------------
  // Shadow of the written registers
  // ---------------------------------------------------------------------------
  // The shadow mirrors writes one cycle late, exactly as the bank does.
  logic [15:0] cal_q;
  logic [9:0] lim_q;
  logic [23:0] msk_q;
  logic lim_en_q;
  logic [16:0] ev_v;
  logic [16:0] st_v;
  logic [16:0] me_v;
  logic signed [FREQ_W:0] mag;
  assign ev_v = I_EVENTS;
  assign st_v = O_STATUS;
  assign me_v = {msk_q[13:0], msk_q[15], msk_q[14], msk_q[22]};
  assign mag = (I_T0_FREQ < 0) ? -I_T0_FREQ : I_T0_FREQ;
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cal_q <= {DHL_RST_CAL_HI, DHL_RST_CAL_LO};
      lim_q <= {DHL_RST_LIM_HI[1:0], DHL_RST_LIM_LO};
      msk_q <= '0;
      lim_en_q <= DHL_RST_AUTO_BW[DHL_BIT_INT_LIMIT];
    end else if (I_BUS.wr) begin
      case (I_BUS.addr)
        DHL_ADDR_AUTO_BW: lim_en_q <= I_BUS.wdata[DHL_BIT_INT_LIMIT];
        DHL_ADDR_CAL_LO: cal_q[7:0] <= I_BUS.wdata;
        DHL_ADDR_CAL_HI: cal_q[15:8] <= I_BUS.wdata;
        DHL_ADDR_LIM_LO: lim_q[7:0] <= I_BUS.wdata;
        DHL_ADDR_LIM_HI: lim_q[9:8] <= I_BUS.wdata[1:0];
        DHL_ADDR_MASK_LO: msk_q[7:0] <= I_BUS.wdata;
        DHL_ADDR_MASK_MID: msk_q[15:8] <= I_BUS.wdata;
        DHL_ADDR_MASK_HI: msk_q[23:16] <= I_BUS.wdata;
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  mon_cal_fixed_a: assert property (O_MON_XTAL_CAL == DHL_CAL_NOMINAL)
    else $error("monitor calibration word moved");
  loop_cal_map_a: assert property (O_LOOP_XTAL_CAL == cal_q)
    else $error("loop calibration word differs from written bytes");
  bound_map_a: assert property (O_PULL_IN_BOUND == lim_q)
    else $error("pull-in bound differs from written bytes");
  limit_hold_a: assert property (O_T0_INT_HOLD == (lim_en_q && mag >= lim_q * LIM_SCALE))
    else $error("integral hold flag wrong");
  report_track_a: assert property (!O_T0_INT_HOLD |=> O_REPORTED_FREQ == $past(I_T0_FREQ))
    else $error("reported frequency did not follow the loop");
  report_freeze_a: assert property (O_T0_INT_HOLD |=> $stable(O_REPORTED_FREQ))
    else $error("reported frequency moved while held");
  status_set_a: assert property (ev_v != 0 |=> (st_v & $past(ev_v)) == $past(ev_v))
    else $error("event flag not recorded");
  irq_mask_gate_a: assert property (O_IRQ == |(st_v & me_v))
    else $error("interrupt output disagrees with flags and masks");
  mask_read_a: assert property (I_BUS.rd && I_BUS.addr == DHL_ADDR_MASK_MID
    |=> O_RD_DATA == $past(msk_q[15:8])) else $error("mask readback wrong");
  cover property (O_IRQ);
  cover property (O_T0_INT_HOLD ##1 !O_T0_INT_HOLD);
  cover property (I_BUS.rd && I_BUS.addr == DHL_ADDR_MASK_MID);
endmodule

bind dhl_config_bank dhl_monitor #(.FREQ_W(FREQ_W), .LIM_SCALE(LIM_SCALE)) i_dhl_monitor (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_BUS(I_BUS), .O_RD_DATA(O_RD_DATA),
  .I_T0_FREQ(I_T0_FREQ), .I_EVENTS(I_EVENTS), .O_STATUS(O_STATUS), .O_IRQ(O_IRQ),
  .O_T0_INT_HOLD(O_T0_INT_HOLD), .O_REPORTED_FREQ(O_REPORTED_FREQ),
  .O_LOOP_XTAL_CAL(O_LOOP_XTAL_CAL), .O_MON_XTAL_CAL(O_MON_XTAL_CAL),
  .O_PULL_IN_BOUND(O_PULL_IN_BOUND));

// ---- dv/dhl_config_bank_tb.sv ----
/*
  Self-checking bench for the holdover and interrupt mask register bank.
  Assumes reads answer one cycle after the strobe and writes land next cycle.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module dhl_config_bank_tb;
  import dhl_pkg::*;
  localparam logic [7:0] RSTV [11] = '{8'h88, 8'h99, 8'h99, 8'h00, 8'h00, 8'h88,
    8'h76, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] HM [7] = '{8'hC0, 8'h80, 8'h05, 8'h10, 8'h18, 8'hC0, 8'h08};
  localparam logic [1:0] SRC [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dhl_bus_type bus = '0;
  dhl_loop_mode_type mode = '0;
  logic signed [18:0] t0 = '0, t4 = '0, fa = '0, sl = '0, rep, hof, e19;
  dhl_event_type ev = '0, clr = '0, st;
  logic [7:0] rdat, r, lo, mid;
  logic irq, h0, h4, abw, ex;
  logic [15:0] lcal, mcal;
  logic [9:0] bnd;
  logic [23:0] m;
  logic [31:0] seed = 32'hEAD805E5;
  logic [7:0] shad [11];
  int miscompares = 0;
  int samples_checked = 0;
  int k, b, fi;

  dhl_config_bank i_dhl_config_bank (.I_CLK(clk), .I_NRST(rst_n), .I_BUS(bus),
    .O_RD_DATA(rdat), .I_MODE(mode), .I_T0_FREQ(t0), .I_T4_FREQ(t4), .I_FAST_AVG_FREQ(fa),
    .I_SLOW_AVG_FREQ(sl), .I_EVENTS(ev), .I_STATUS_CLR(clr), .O_STATUS(st), .O_IRQ(irq),
    .O_T0_INT_HOLD(h0), .O_T4_INT_HOLD(h4), .O_REPORTED_FREQ(rep), .O_HOLDOVER_FREQ(hof),
    .O_LOOP_XTAL_CAL(lcal), .O_MON_XTAL_CAL(mcal), .O_PULL_IN_BOUND(bnd), .O_AUTO_BW_SEL(abw));

  initial begin
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Registers with spare bits read those bits back as zero.
  function automatic logic [7:0] rmask(int i);
    return (i == 0) ? 8'h88 : (i == 7) ? 8'h03 : (i == 10) ? 8'h40 : 8'hFF;
  endfunction
  function automatic logic mbit(int i, logic [23:0] mm);
    return (i >= 3) ? mm[i-3] : (i == 2) ? mm[15] : (i == 1) ? mm[14] : mm[22];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rck(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    `CHK(rdat, e)
  endtask
  task automatic pulse(input logic [16:0] s, input logic [16:0] c);
    @(posedge clk);
    ev <= s;
    clr <= c;
    @(posedge clk);
    ev <= '0;
    clr <= '0;
    @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 11; k++) rck(8'(59 + k), RSTV[k]);
    rck(8'h46, DHL_RD_UNMAPPED);
    `CHK(mcal, DHL_CAL_NOMINAL)
    $display("reset values done");
    shad = RSTV;
    for (int n = 0; n < 24; n++) begin
      k = xs() % 11;
      r = 8'(xs());
      if (k == 5) r[DHL_BIT_READ_AVG] = 1'b0;
      wr(8'(59 + k), r);
      shad[k] = r;
      rck(8'(59 + k), r & rmask(k));
    end
    wr(8'h46, 8'hFF);
    rck(8'h46, DHL_RD_UNMAPPED);
    `CHK(lcal, {shad[2], shad[1]})
    `CHK(bnd, {shad[7][1:0], shad[6]})
    `CHK(abw, shad[0][7])
    `CHK(mcal, DHL_CAL_NOMINAL)
    $display("register access done");
    wr(DHL_ADDR_AUTO_BW, 8'h00);
    @(posedge clk);
    fa <= 19'(xs());
    sl <= 19'(xs());
    t0 <= 19'(xs());
    for (k = 0; k < 2; k++) begin
      r = k ? 8'hA0 : 8'hE0;
      wr(DHL_ADDR_HOLD_MODE, r);
      e19 = k ? sl : fa;
      rck(DHL_ADDR_HOLD_LO, e19[7:0]);
      rck(DHL_ADDR_HOLD_MID, e19[15:8]);
      rck(DHL_ADDR_HOLD_MODE, {r[7:3], e19[18:16]});
    end
    lo = 8'(xs());
    mid = 8'(xs());
    wr(DHL_ADDR_HOLD_LO, lo);
    wr(DHL_ADDR_HOLD_MID, mid);
    for (k = 0; k < 7; k++) begin
      wr(DHL_ADDR_HOLD_MODE, HM[k]);
      @(posedge clk);
      mode <= '{in_holdover: (k < 3), in_mini_holdover: (k >= 3),
        manual_holdover: (SRC[k] == 2'h2)};
      repeat (3) @(posedge clk);
      e19 = (SRC[k] == 0) ? fa : (SRC[k] == 1) ? sl : (SRC[k] == 2) ? {HM[k][2:0], mid, lo} : t0;
      @(negedge clk);
      `CHK(hof, e19)
      @(posedge clk);
      mode <= '0;
    end
    $display("holdover source done");
    for (int p = 0; p < 2; p++) begin
      m = p ? ~m : 24'(xs());
      wr(DHL_ADDR_MASK_LO, m[7:0]);
      wr(DHL_ADDR_MASK_MID, m[15:8]);
      wr(DHL_ADDR_MASK_HI, m[23:16]);
      rck(DHL_ADDR_MASK_MID, m[15:8]);
      for (k = 0; k < 17; k++) begin
        pulse(17'(1) << k, '0);
        `CHK(st, 17'(1) << k)
        `CHK(irq, mbit(k, m))
        pulse('0, 17'(1) << k);
        `CHK(irq, 1'b0)
      end
    end
    pulse('1, '1);
    `CHK(st, 17'h1FFFF)
    pulse('0, '1);
    $display("interrupt masks done");
    for (int n = 0; n < 32; n++) begin
      b = 1 + xs() % 36;
      r = (xs() % 2) ? 8'h08 : 8'h00;
      wr(DHL_ADDR_LIM_LO, 8'(b));
      wr(DHL_ADDR_LIM_HI, 8'h00);
      wr(DHL_ADDR_AUTO_BW, r);
      fi = (n % 4 == 0) ? b * DHL_LIM_SCALE : (n % 4 == 1) ? b * DHL_LIM_SCALE - 1 :
        (n % 4 == 2) ? -b * DHL_LIM_SCALE : $signed(19'(xs()));
      @(posedge clk);
      t0 <= 19'(fi);
      t4 <= 19'(-fi);
      @(negedge clk);
      ex = r[3] && ((fi < 0) ? -fi : fi) >= b * DHL_LIM_SCALE;
      `CHK(h0, ex)
      `CHK(h4, ex)
    end
    @(posedge clk);
    t0 <= '0;
    wr(DHL_ADDR_AUTO_BW, 8'h08);
    @(posedge clk);
    t0 <= 19'(b * DHL_LIM_SCALE);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(rep, 19'h0)
    wr(DHL_ADDR_AUTO_BW, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(rep, 19'(b * DHL_LIM_SCALE))
    $display("integral limit done");
    tally_and_finish();
  end
endmodule
